//--- shared/rtc_trim_pkg.sv
package rtc_trim_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CLOCK_TRIM_CONTROL = 8'h18;
	localparam logic [7:0] OFS_IRQ_ENABLE_MASK    = 8'h1C;
	localparam logic [7:0] OFS_RAW_IRQ_STATUS     = 8'h20;
	localparam logic [7:0] OFS_MASKED_IRQ_STATUS  = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLEAR          = 8'h28;
	localparam logic [7:0] OFS_EVENT_STATUS       = 8'h40;
	localparam logic [7:0] OFS_EVENT_MASK         = 8'h44;

	// ----------------------------------------
	// clock trim control fields
	// ----------------------------------------
	localparam int DIV_LSB  = 0;
	localparam int DIV_W    = 15;
	localparam int DEL_LSB  = 16;
	localparam int DEL_W    = 10;
	localparam int LOCK_BIT = 26;
	localparam logic [DIV_W-1:0] DIV_RESET = 15'h7FFF;
	localparam logic [DEL_W-1:0] DEL_RESET = 10'h000;
	// last index of the 1023-cycle trim window
	localparam logic [DEL_W-1:0] TRIM_WIN_LAST = 10'h3FE;

	// ----------------------------------------
	// interrupt bit positions
	// ----------------------------------------
	localparam int IRQ_W    = 2;
	localparam int CW_BIT   = 0;
	localparam int TM_BIT   = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	// event status bits (read clears)
	localparam int EVT_W       = 4;
	localparam int EVT_CW      = 0;
	localparam int EVT_TM      = 1;
	localparam int EVT_DISCARD = 2;
	localparam int EVT_SECOND  = 3;
	localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

	// ----------------------------------------
	// bus encodings
	// ----------------------------------------
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic        HRESP_OKAY = 1'h0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

//--- rtl/one_hz_divider.sv
`timescale 1ns/1ps
module one_hz_divider
	import rtc_trim_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic [DIV_W-1:0] div_factor,
	input  wire logic [DEL_W-1:0] del_count,
	output logic                  one_second_clock
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [DEL_W-1:0] win_cnt_ff;   // position in trim window
	logic [DIV_W-1:0] div_cnt_ff;   // trimmed cycles this second
	logic             deleting;     // this slow cycle is dropped

	// first del_count cycles of each window are swallowed
	assign deleting = (win_cnt_ff < del_count); // [R2]

	// ----------------------------------------
	// trim window counter
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			win_cnt_ff <= '0;
		else if (win_cnt_ff == TRIM_WIN_LAST) // [R2]
			win_cnt_ff <= '0;
		else
			win_cnt_ff <= win_cnt_ff + 1'b1;
	end

	// ----------------------------------------
	// divider; >= tolerates a factor shrinking mid-count
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_cnt_ff       <= '0;
			one_second_clock <= 1'b0;
		end
		else if (deleting) // [R3]
			one_second_clock <= 1'b0;
		else if (div_cnt_ff >= div_factor) // [R13]
		begin
			div_cnt_ff       <= '0;
			one_second_clock <= 1'b1;
		end
		else
		begin
			div_cnt_ff       <= div_cnt_ff + 1'b1;
			one_second_clock <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// zero trim: the divider moves on every single cycle
	AST_NO_TRIM_NO_DROP: assert property ( // [R3]
		(del_count == '0 && div_cnt_ff < div_factor) |=> div_cnt_ff == $past(div_cnt_ff) + 1'b1)
		else $error("zero trim count still drops cycles");
	// a dropped cycle freezes the count and gives no pulse
	AST_DROP_HOLDS: assert property (deleting |=> $stable(div_cnt_ff) && !one_second_clock) // [R3]
		else $error("dropped cycle moved the divider");
	AST_WRAP_PULSE: assert property ( // [R13]
		(!deleting && div_cnt_ff >= div_factor) |=> (one_second_clock && div_cnt_ff == '0))
		else $error("divider wrap gave no second pulse");

endmodule

//--- rtl/rtc_trim_lock_irq.sv
// Summary of operation
// [R1] locked clockwatch ignores divider factor writes
// [R2] ten-bit trim count drops cycles per window
// [R3] zero drops none, up to 1023 dropped
// [R4] locked clockwatch ignores trim count writes
// [R5] bit 26 enables clockwatch, resets low
// [R6] once enabled, control writes discarded until reset
// [R7] mask bit 0 gates clockwatch interrupt
// [R8] mask bit 1 gates timer interrupt
// [R9] raw status shows unmasked flags
// [R10] masked status drives both interrupt outputs
// [R11] clear bit 0 drops clockwatch flag
// [R12] clear bit 1 drops timer flag
// [R13] second pulse every factor plus one
// [R14] timer zero event sets timer flag
// [R15] flags sticky, new event beats clear
// [R16] clockwatch match event sets clockwatch flag
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module rtc_trim_lock_irq
	import rtc_trim_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// events from the counting logic
	input  wire logic        clockwatch_match,
	input  wire logic        timer_zero,
	// outputs
	output logic             one_second_clock,
	output logic             clockwatch_enable_lock,
	output logic             clockwatch_irq_out,
	output logic             timer_irq_out,
	output logic             rtc_irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic             addr_ok;      // address phase taken
	logic             wr_pend_ff;   // write data phase pending
	logic             rd_pend_ff;   // read wait cycle pending
	logic [7:0]       wr_addr_ff;   // latched write offset
	logic [7:0]       rd_addr_ff;   // latched read offset
	logic [31:0]      rd_mux;       // read data selection

	logic [DIV_W-1:0] div_ff;       // one_hz_divider_factor
	logic [DEL_W-1:0] del_ff;       // trim_delete_count
	logic             lock_ff;      // clockwatch_enable_lock

	logic [IRQ_W-1:0] mask_ff;      // interrupt_enable_mask
	logic [IRQ_W-1:0] raw_ff;       // raw_interrupt_status
	logic [IRQ_W-1:0] nxt_mask;     // mask after this cycle
	logic [IRQ_W-1:0] nxt_raw;      // raw flags after this cycle
	logic [IRQ_W-1:0] irq_events;   // incoming interrupt events
	logic [IRQ_W-1:0] irq_clr;      // clear bits of this cycle

	logic [EVT_W-1:0] evt_ff;       // read-clear event status
	logic [EVT_W-1:0] evt_mask_ff;  // event mask
	logic [EVT_W-1:0] nxt_evt;      // event status next
	logic [EVT_W-1:0] nxt_evt_mask; // event mask next
	logic [EVT_W-1:0] evt_in;       // event sources

	logic             wr_ctrl;      // control write this cycle
	logic             wr_mask;      // mask write
	logic             wr_clear;     // clear write
	logic             wr_evt_mask;  // event mask write
	logic             rd_evt;       // event status being read
	logic             sec_pulse;    // trimmed one second tick

	// ----------------------------------------
	// bus address phase
	// ----------------------------------------
	// only a ready bus starts a transfer; while we stall, the
	// master holds its address and we must not take it twice
	assign addr_ok = hsel && htrans[1] && hready;

	// latch the access kind and its offset
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			rd_addr_ff <= '0;
		end
		else
		begin
			// narrower writes are dropped, only words are supported
			wr_pend_ff <= addr_ok && hwrite && (hsize == HSIZE_WORD);
			rd_pend_ff <= addr_ok && !hwrite;
			if (addr_ok)
			begin
				wr_addr_ff <= haddr[7:0];
				rd_addr_ff <= haddr[7:0];
			end
		end
	end

	// ----------------------------------------
	// ready and response
	// ----------------------------------------
	// a read waits one cycle so that a write just before it has
	// landed; writes finish with no wait at all
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
		else
		begin
			hreadyout <= !(addr_ok && !hwrite);
			hresp     <= HRESP_OKAY;
		end
	end

	// ----------------------------------------
	// write strobes and the event status read strobe
	// ----------------------------------------
	assign wr_ctrl     = wr_pend_ff && (wr_addr_ff == OFS_CLOCK_TRIM_CONTROL);
	assign wr_mask     = wr_pend_ff && (wr_addr_ff == OFS_IRQ_ENABLE_MASK);
	assign wr_clear    = wr_pend_ff && (wr_addr_ff == OFS_IRQ_CLEAR);
	assign wr_evt_mask = wr_pend_ff && (wr_addr_ff == OFS_EVENT_MASK);
	assign rd_evt      = rd_pend_ff && (rd_addr_ff == OFS_EVENT_STATUS);

	// ----------------------------------------
	// clock trim control
	// ----------------------------------------
	// the lock covers the whole register, lock bit included,
	// so only power-on reset can release it
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_ff  <= DIV_RESET; // [R13]
			del_ff  <= DEL_RESET;
			lock_ff <= 1'b0;      // [R5]
		end
		else if (wr_ctrl && !lock_ff) // [R1] [R4] [R6]
		begin
			div_ff  <= hwdata[DIV_LSB +: DIV_W];
			del_ff  <= hwdata[DEL_LSB +: DEL_W]; // [R2]
			lock_ff <= hwdata[LOCK_BIT];         // [R5]
		end
	end

	assign clockwatch_enable_lock = lock_ff;

	// ----------------------------------------
	// trimmed one second divider
	// ----------------------------------------
	one_hz_divider u_div
	(
		.sys_clk          (sys_clk),
		.arst_n           (arst_n),
		.div_factor       (div_ff),
		.del_count        (del_ff),
		.one_second_clock (sec_pulse)
	);

	assign one_second_clock = sec_pulse;

	// ----------------------------------------
	// interrupt mask and raw flags
	// ----------------------------------------
	assign irq_events[CW_BIT] = clockwatch_match; // [R16]
	assign irq_events[TM_BIT] = timer_zero;       // [R14]
	assign irq_clr            = wr_clear ? hwdata[IRQ_W-1:0] : IRQ_RESET;

	// next values are formed here so that the outputs can be
	// flops yet still line up with the status registers
	always_comb
	begin
		nxt_mask = wr_mask ? hwdata[IRQ_W-1:0] : mask_ff; // [R7] [R8]
		// a fresh event wins over a clear in the same cycle
		nxt_raw  = (raw_ff & ~irq_clr) | irq_events; // [R11] [R12] [R15]
	end

	// mask register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			mask_ff <= IRQ_RESET;
		else
			mask_ff <= nxt_mask;
	end

	// sticky raw flags
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			raw_ff <= IRQ_RESET; // [R9]
		else
			raw_ff <= nxt_raw;
	end

	// masked outputs, same timing as the masked status read
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clockwatch_irq_out <= 1'b0;
			timer_irq_out      <= 1'b0;
		end
		else
		begin
			clockwatch_irq_out <= nxt_raw[CW_BIT] && nxt_mask[CW_BIT]; // [R10]
			timer_irq_out      <= nxt_raw[TM_BIT] && nxt_mask[TM_BIT]; // [R10]
		end
	end

	// ----------------------------------------
	// read-clear event status and combined interrupt
	// ----------------------------------------
	assign evt_in[EVT_CW]      = clockwatch_match;
	assign evt_in[EVT_TM]      = timer_zero;
	assign evt_in[EVT_DISCARD] = wr_ctrl && lock_ff;
	assign evt_in[EVT_SECOND]  = sec_pulse;

	// a read wipes the snapshot it returns; new events survive
	always_comb
	begin
		nxt_evt      = (rd_evt ? EVT_RESET : evt_ff) | evt_in;
		nxt_evt_mask = wr_evt_mask ? hwdata[EVT_W-1:0] : evt_mask_ff;
	end

	// event status and its mask
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evt_ff      <= EVT_RESET;
			evt_mask_ff <= EVT_RESET;
		end
		else
		begin
			evt_ff      <= nxt_evt;
			evt_mask_ff <= nxt_evt_mask;
		end
	end

	// single level interrupt line
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rtc_irq <= 1'b0;
		else
			rtc_irq <= |(nxt_evt & nxt_evt_mask);
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// reserved bits and unmapped offsets read as zero; the
	// clear register is write-only and reads as zero too
	always_comb
	begin
		rd_mux = RDATA_ZERO;
		case (rd_addr_ff)
			OFS_CLOCK_TRIM_CONTROL:
			begin
				rd_mux[DIV_LSB +: DIV_W] = div_ff; // [R1]
				rd_mux[DEL_LSB +: DEL_W] = del_ff; // [R4]
				rd_mux[LOCK_BIT]         = lock_ff; // [R5]
			end
			OFS_IRQ_ENABLE_MASK:   rd_mux[IRQ_W-1:0] = mask_ff;
			OFS_RAW_IRQ_STATUS:    rd_mux[IRQ_W-1:0] = raw_ff; // [R9]
			OFS_MASKED_IRQ_STATUS: rd_mux[IRQ_W-1:0] = raw_ff & mask_ff; // [R10]
			OFS_EVENT_STATUS:      rd_mux[EVT_W-1:0] = evt_ff;
			OFS_EVENT_MASK:        rd_mux[EVT_W-1:0] = evt_mask_ff;
			default:               rd_mux = RDATA_ZERO;
		endcase
	end

	// data stands from the wait cycle until the next read
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			hrdata <= RDATA_ZERO;
		else if (rd_pend_ff)
			hrdata <= rd_mux;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_locked_ctrl_write;
		wr_ctrl && lock_ff;
	endsequence

	sequence s_clear_cw;
		wr_clear && hwdata[CW_BIT] && !clockwatch_match;
	endsequence

	sequence s_clear_tm;
		wr_clear && hwdata[TM_BIT] && !timer_zero;
	endsequence

	// one stall cycle, then the read data stands
	sequence s_read_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	AST_DIV_LOCKED: assert property (s_locked_ctrl_write |=> $stable(div_ff)) // [R1]
		else $error("divider factor changed while locked");
	AST_DEL_LOCKED: assert property (s_locked_ctrl_write |=> $stable(del_ff)) // [R4]
		else $error("trim count changed while locked");
	AST_LOCK_SET: assert property (wr_ctrl && hwdata[LOCK_BIT] |=> lock_ff) // [R5]
		else $error("lock bit write not taken");
	AST_LOCK_HOLDS: assert property (lock_ff |=> lock_ff) // [R6]
		else $error("lock released without reset");
	AST_MASK_CW: assert property (wr_mask |=> mask_ff[CW_BIT] == $past(hwdata[CW_BIT])) // [R7]
		else $error("clockwatch mask not written");
	AST_MASK_TM: assert property (wr_mask |=> mask_ff[TM_BIT] == $past(hwdata[TM_BIT])) // [R8]
		else $error("timer mask not written");
	AST_RAW_READ: assert property ( // [R9]
		rd_pend_ff && rd_addr_ff == OFS_RAW_IRQ_STATUS |=>
		hreadyout && hrdata[IRQ_W-1:0] == $past(raw_ff))
		else $error("raw status read wrong");
	AST_OUT_MASKED: assert property ( // [R10]
		clockwatch_irq_out == (raw_ff[CW_BIT] && mask_ff[CW_BIT]) &&
		timer_irq_out == (raw_ff[TM_BIT] && mask_ff[TM_BIT]))
		else $error("interrupt output not raw and mask");
	AST_CLEAR_CW: assert property (s_clear_cw |=> !raw_ff[CW_BIT]) // [R11]
		else $error("clockwatch flag not cleared");
	AST_CLEAR_TM: assert property (s_clear_tm |=> !raw_ff[TM_BIT]) // [R12]
		else $error("timer flag not cleared");
	AST_TIMER_SET: assert property (timer_zero |=> raw_ff[TM_BIT]) // [R14]
		else $error("timer zero lost");
	AST_CW_SET: assert property (clockwatch_match |=> raw_ff[CW_BIT]) // [R16]
		else $error("clockwatch match lost");
	AST_STICKY: assert property ( // [R15]
		raw_ff[CW_BIT] && !(wr_clear && hwdata[CW_BIT]) |=> raw_ff[CW_BIT])
		else $error("clockwatch flag dropped without clear");
	// masked status read returns raw and mask of the wait cycle
	AST_MASKED_READ: assert property ( // [R10]
		rd_pend_ff && rd_addr_ff == OFS_MASKED_IRQ_STATUS |=>
		hrdata[IRQ_W-1:0] == $past(raw_ff & mask_ff))
		else $error("masked status read wrong");
	// every status read stalls exactly once
	AST_READ_WAIT: assert property (addr_ok && !hwrite |=> s_read_wait) // [R9]
		else $error("read wait state wrong");

endmodule

//--- test/rtc_trim_lock_and_irq_test.sv
`timescale 1ns/1ps
module rtc_trim_lock_and_irq_test
	import rtc_trim_pkg::*;
();
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        sys_clk;          // 10 mhz system clock
	logic        arst_n;           // power-on reset
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;        // also the bus hready
	logic        hresp;
	logic [31:0] hrdata;
	logic        clockwatch_match; // match event in
	logic        timer_zero;       // timer event in
	logic        one_second_clock;
	logic        clockwatch_enable_lock;
	logic        clockwatch_irq_out;
	logic        timer_irq_out;
	logic        rtc_irq;
	int          n_mismatch;       // failed comparisons
	int          total_checks;     // all comparisons

	rtc_trim_lock_irq dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.clockwatch_match(clockwatch_match), .timer_zero(timer_zero),
		.one_second_clock(one_second_clock),
		.clockwatch_enable_lock(clockwatch_enable_lock),
		.clockwatch_irq_out(clockwatch_irq_out), .timer_irq_out(timer_irq_out),
		.rtc_irq(rtc_irq)
	);

	// free-running clock, half period 50 ns
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// report and compare
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		total_checks++;
		if (got != exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	// expected control word from its fields
	function automatic logic [31:0] ctrl(input logic l, input logic [9:0] d,
		input logic [14:0] v);
		return {5'h00, l, d, 1'h0, v};
	endfunction

	// masked status is raw gated by mask
	function automatic logic [31:0] masked_exp(input logic [1:0] r, input logic [1:0] m);
		return {30'h0000_0000, r & m};
	endfunction

	// ----------------------------------------
	// bus master and event drivers
	// ----------------------------------------
	// sampled on the falling edge, where hready has settled, then act on the rise
	task automatic wait_rdy(output logic [31:0] q);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (hreadyout !== 1'b1 && n < 100)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 100)
		begin
			n_mismatch++;
			finish_test();
		end
		q = hrdata;
		chk_bit(hresp, HRESP_OKAY);
		@(posedge sys_clk);
	endtask

	task automatic bus(input logic w, input logic [2:0] sz, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		hsize <= sz;
		wait_rdy(q);
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy(q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, HSIZE_WORD, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, HSIZE_WORD, a, 32'h0000_0000, q);
	endtask

	// one-cycle event pulse, checked at the following falling edge
	task automatic pulse(input logic cw, input logic tm);
		@(posedge sys_clk);
		clockwatch_match <= cw;
		timer_zero <= tm;
		@(posedge sys_clk);
		clockwatch_match <= 1'b0;
		timer_zero <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
	endtask

	// cycles between two second pulses, bounded
	task automatic period(output int p);
		int n;
		n = 0;
		while (one_second_clock !== 1'b1 && n < 2000)
		begin
			@(negedge sys_clk);
			n++;
		end
		p = 0;
		do
		begin
			@(negedge sys_clk);
			p++;
		end
		while (one_second_clock !== 1'b1 && p < 2000);
		if (n >= 2000 || p >= 2000)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask

	// hang guard
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		n_mismatch++;
		finish_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int          c;
		logic [31:0] q;
		logic [1:0]  m;
		logic [1:0]  ev;
		logic [14:0] f;
		logic [9:0]  k;
		n_mismatch = 0;
		total_checks = 0;
		{hsel, hwrite, clockwatch_match, timer_zero} = 4'h0;
		{haddr, hwdata} = 64'h0000_0000_0000_0000;
		htrans = 2'b00;
		hsize = HSIZE_WORD;
		arst_n = 1'b0;
		c = $urandom(32'h3bd8);
		do_reset();
		// reset values, clear reads zero, unmapped place reads zero
		rd(OFS_CLOCK_TRIM_CONTROL, q);
		chk_word(q, ctrl(1'b0, DEL_RESET, DIV_RESET));
		rd(OFS_IRQ_ENABLE_MASK, q);
		chk_word(q, 32'h0000_0000);
		rd(OFS_RAW_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0000);
		rd(OFS_MASKED_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0000);
		rd(OFS_IRQ_CLEAR, q);
		chk_word(q, RDATA_ZERO);
		rd(8'h30, q);
		chk_word(q, RDATA_ZERO);
		chk_bit(clockwatch_enable_lock, 1'b0);
		// random masks against random events
		repeat (16)
		begin
			m = 2'($urandom);
			ev = 2'($urandom);
			wr(OFS_IRQ_ENABLE_MASK, {30'h0000_0000, m});
			wr(OFS_IRQ_CLEAR, 32'h0000_0003);
			pulse(ev[0], ev[1]);
			chk_bit(clockwatch_irq_out, ev[0] & m[0]);
			chk_bit(timer_irq_out, ev[1] & m[1]);
			rd(OFS_IRQ_ENABLE_MASK, q);
			chk_word(q, {30'h0000_0000, m});
			rd(OFS_RAW_IRQ_STATUS, q);
			chk_word(q, {30'h0000_0000, ev});
			rd(OFS_MASKED_IRQ_STATUS, q);
			chk_word(q, masked_exp(ev, m));
		end
		// clear bits one at a time; an event during the clear wins
		wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0003);
		pulse(1'b1, 1'b1);
		wr(OFS_IRQ_CLEAR, 32'h0000_0000);
		rd(OFS_RAW_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0003);
		wr(OFS_IRQ_CLEAR, 32'h0000_0001);
		rd(OFS_RAW_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0002);
		// outputs are looked at off the launching edge
		@(negedge sys_clk);
		chk_bit(clockwatch_irq_out, 1'b0);
		@(posedge sys_clk);
		timer_zero <= 1'b1;
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		timer_zero <= 1'b0;
		rd(OFS_RAW_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0002);
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		rd(OFS_RAW_IRQ_STATUS, q);
		chk_word(q, 32'h0000_0000);
		@(negedge sys_clk);
		chk_bit(timer_irq_out, 1'b0);
		// a byte-sized write leaves the mask alone
		bus(1'b1, 3'h0, OFS_IRQ_ENABLE_MASK, 32'h0000_0000, q);
		rd(OFS_IRQ_ENABLE_MASK, q);
		chk_word(q, 32'h0000_0003);
		wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0000);
		// summary interrupt: raise, mask, clear by reading
		wr(OFS_EVENT_MASK, 32'h0000_0000);
		rd(OFS_EVENT_STATUS, q);
		wr(OFS_EVENT_MASK, 32'h0000_0002);
		@(negedge sys_clk);
		chk_bit(rtc_irq, 1'b0);
		pulse(1'b0, 1'b1);
		chk_bit(rtc_irq, 1'b1);
		rd(OFS_EVENT_STATUS, q);
		chk_bit(q[EVT_TM], 1'b1);
		repeat (2) @(negedge sys_clk);
		chk_bit(rtc_irq, 1'b0);
		wr(OFS_EVENT_MASK, 32'h0000_0000);
		// trim: with factor 0 every kept cycle pulses, so any 1023 cycles hold 1023-k
		for (int i = 0; i < 3; i++)
		begin
			k = (i == 0) ? 10'h000 : (i == 1) ? 10'(1 + $urandom % 1022) : 10'h3FF;
			wr(OFS_CLOCK_TRIM_CONTROL, ctrl(1'b0, k, 15'h0000));
			repeat (4) @(negedge sys_clk);
			c = 0;
			repeat (1023)
			begin
				@(negedge sys_clk);
				if (one_second_clock === 1'b1)
					c++;
			end
			chk_count(c, 1023 - int'(k));
		end
		// period is factor plus one
		f = 15'(1 + $urandom % 8);
		wr(OFS_CLOCK_TRIM_CONTROL, ctrl(1'b0, 10'h000, f));
		period(c);
		chk_count(c, int'(f) + 1);
		// lock, then every later control write is dropped
		wr(OFS_CLOCK_TRIM_CONTROL, ctrl(1'b1, 10'h000, f));
		@(negedge sys_clk);
		chk_bit(clockwatch_enable_lock, 1'b1);
		// the locking write itself is no discard; seconds were seen
		rd(OFS_EVENT_STATUS, q);
		chk_bit(q[EVT_DISCARD], 1'b0);
		chk_bit(q[EVT_SECOND], 1'b1);
		wr(OFS_CLOCK_TRIM_CONTROL, ctrl(1'b0, 10'h155, 15'h0002));
		rd(OFS_CLOCK_TRIM_CONTROL, q);
		chk_word(q, ctrl(1'b1, 10'h000, f));
		rd(OFS_EVENT_STATUS, q);
		chk_bit(q[EVT_DISCARD], 1'b1);
		period(c);
		chk_count(c, int'(f) + 1);
		chk_bit(clockwatch_enable_lock, 1'b1);
		// only power-on reset lifts the lock
		do_reset();
		rd(OFS_CLOCK_TRIM_CONTROL, q);
		chk_word(q, ctrl(1'b0, DEL_RESET, DIV_RESET));
		chk_bit(clockwatch_enable_lock, 1'b0);
		finish_test();
	end
endmodule
